/* hdl/phy_regs_pkg.sv */
// constants for the phy control, status and led register bank
// assumes one 125 MHz system clock and a 5-bit management address
package phy_regs_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
  localparam logic [4:0] ADDR_STAT_ONE = 5'h01;
  localparam logic [4:0] ADDR_CTRL_TWO = 5'h10;
  localparam logic [4:0] ADDR_STAT_TWO = 5'h11;
  localparam logic [4:0] ADDR_IRQ_EN   = 5'h12;
  localparam logic [4:0] ADDR_IRQ_REQ  = 5'h13;
  localparam logic [4:0] ADDR_LED_CTL  = 5'h14;

  // ****************************************
  // field positions
  // ****************************************
  localparam int DUPLEX_BIT     = 8;
  localparam int LATCH_LINK_BIT = 2;
  localparam int FORCE_LINK_BIT = 14;
  localparam int TX_ACT_BIT     = 13;
  localparam int RX_ACT_BIT     = 12;
  localparam int COL_BIT        = 11;
  localparam int LINK_NOW_BIT   = 10;
  localparam int LED_A_LSB      = 8;
  localparam int LED_B_LSB      = 4;
  localparam int STRETCH_SEL_LSB = 2;
  localparam int STRETCH_ON_BIT = 1;
  localparam int PLNK_IE_BIT    = 4;
  localparam int PGE_IE_BIT     = 1;
  localparam int PLNK_IF_BIT    = 4;
  localparam int PG_IF_BIT      = 2;
  localparam int LINK_IRQ_BIT   = 4;

  // ****************************************
  // masks and values after reset
  // ****************************************
  localparam logic [15:0] CTRL_ONE_WMASK = 16'hCD80;
  localparam logic [15:0] CTRL_TWO_WMASK = 16'h7FFF;
  localparam logic [15:0] IRQ_EN_WMASK   = 16'h0012;
  localparam logic [15:0] STAT_ONE_FIXED = 16'h1800;
  localparam logic [15:0] CTRL_ONE_RST   = 16'h0000;
  localparam logic [15:0] CTRL_TWO_RST   = 16'h0000;
  localparam logic [15:0] LED_CTL_RST    = 16'h3422;
  localparam logic [15:0] IRQ_EN_RST     = 16'h0000;
  localparam logic [7:0]  EIR_IMPL_MASK  = 8'h7B;

  // ****************************************
  // led function codes
  // ****************************************
  typedef enum logic [3:0] {
    LED_TX       = 4'h1,
    LED_RX       = 4'h2,
    LED_COL      = 4'h3,
    LED_LINK     = 4'h4,
    LED_DUPLEX   = 4'h5,
    LED_TXRX     = 4'h7,
    LED_ON       = 4'h8,
    LED_OFF      = 4'h9,
    LED_FAST     = 4'hA,
    LED_SLOW     = 4'hB,
    LED_LINK_RX  = 4'hC,
    LED_LINK_ALL = 4'hD
  } led_func_t;

  // ****************************************
  // times and derived cycle counts
  // ****************************************
  localparam int CLK_FREQ_MHZ          = 125;
  localparam int NORMAL_STRETCH_TIME_MS = 40;
  localparam int MEDIUM_STRETCH_TIME_MS = 80;
  localparam int LONG_STRETCH_TIME_MS   = 160;
  localparam int BLINK_FAST_HALF_MS     = 100;
  localparam int BLINK_SLOW_HALF_MS     = 500;
  localparam int NORMAL_STRETCH_CYC = NORMAL_STRETCH_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int MEDIUM_STRETCH_CYC = MEDIUM_STRETCH_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int LONG_STRETCH_CYC   = LONG_STRETCH_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int BLINK_FAST_CYC     = BLINK_FAST_HALF_MS * 1000 * CLK_FREQ_MHZ;
  localparam int BLINK_SLOW_CYC     = BLINK_SLOW_HALF_MS * 1000 * CLK_FREQ_MHZ;

endpackage

/* hdl/led_drive_if.sv */
// carrier between the register bank and one led driver
// assumes both ends sit on the same system clock
`timescale 1ns/100ps
interface led_drive_if;
  logic [3:0]  func;
  logic        stretch_on;
  logic [31:0] stretch_cyc;
  logic        tx;
  logic        rx;
  logic        col;
  logic        link;
  logic        duplex;
  logic        blink_fast;
  logic        blink_slow;
  logic        led;

  modport ctrl (output func, stretch_on, stretch_cyc, tx, rx, col, link, duplex,
                blink_fast, blink_slow, input led);
  modport drv  (input func, stretch_on, stretch_cyc, tx, rx, col, link, duplex,
                blink_fast, blink_slow, output led);
endinterface

/* hdl/led_driver.sv */
// one led output with selectable function and pulse stretching
// assumes status levels already synchronised to i_clk
`timescale 1ns/100ps
module led_driver
  import phy_regs_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // settings and status
  led_drive_if.drv  bus
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        led;
  } drv_state_t;

  drv_state_t q;
  drv_state_t d;
  logic       ev;
  logic       can_str;
  logic       always_str;
  logic       shown;

  // ****************************************
  // event select, stretch and output
  // ****************************************
  always_comb
  begin
    d          = q;
    ev         = 1'b0;
    can_str    = 1'b0;
    always_str = 1'b0;
    case (bus.func)
      LED_TX:       begin ev = bus.tx;            can_str = 1'b1; end
      LED_RX:       begin ev = bus.rx;            can_str = 1'b1; end
      LED_COL:      begin ev = bus.col;           can_str = 1'b1; end
      LED_TXRX:     begin ev = bus.tx | bus.rx;   can_str = 1'b1; end
      LED_LINK_RX:  begin ev = bus.rx;            always_str = 1'b1; end
      LED_LINK_ALL: begin ev = bus.tx | bus.rx;   always_str = 1'b1; end
      default:      ev = 1'b0;
    endcase
    // a fresh event restarts the stretch so bursts read as one pulse
    if (ev)
      d.cnt = bus.stretch_cyc;
    else if (q.cnt != 32'h0000_0000)
      d.cnt = q.cnt - 32'h0000_0001;
    if (always_str || (can_str && bus.stretch_on))
      shown = ev | (q.cnt != 32'h0000_0000);
    else
      shown = ev;
    case (bus.func)
      LED_TX, LED_RX, LED_COL, LED_TXRX: d.led = shown;
      LED_LINK:     d.led = bus.link;
      LED_DUPLEX:   d.led = bus.duplex;
      LED_ON:       d.led = 1'b1;
      LED_OFF:      d.led = 1'b0;
      LED_FAST:     d.led = bus.blink_fast;
      LED_SLOW:     d.led = bus.blink_slow;
      // lit on link, activity blinks it dark
      LED_LINK_RX, LED_LINK_ALL: d.led = bus.link ^ shown;
      default:      d.led = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      q <= '0;
    else if (i_ce)
      q <= d;
  end

  assign bus.led = q.led;

endmodule

/* hdl/phy_control_status_led_regs.sv */
// phy control, status and led register bank with interrupt front end
// assumes a management port on i_clk and raw phy status from pins
`timescale 1ns/100ps
module phy_control_status_led_regs
  import phy_regs_pkg::*;
#(
  parameter int STRETCH_N_CYC = NORMAL_STRETCH_CYC,
  parameter int STRETCH_M_CYC = MEDIUM_STRETCH_CYC,
  parameter int STRETCH_L_CYC = LONG_STRETCH_CYC,
  parameter int BLINK_F_CYC   = BLINK_FAST_CYC,
  parameter int BLINK_S_CYC   = BLINK_SLOW_CYC
)
(
  // clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // management port
  input  wire logic [4:0]  i_mii_addr,
  input  wire logic        i_mii_wr,
  input  wire logic        i_mii_rd,
  input  wire logic [15:0] i_mii_wdata,
  output logic      [15:0] o_mii_rdata,
  output logic             o_mii_rvalid,
  // raw phy status pins
  input  wire logic        i_link_pin,
  input  wire logic        i_tx_pin,
  input  wire logic        i_rx_pin,
  // phy mode outputs
  output logic             o_full_duplex,
  output logic             o_tx_allowed,
  output logic             o_half_duplex_loopback_off,
  output logic             o_rx_input_normal,
  // leds
  output logic             o_led_a_a,
  output logic             o_led_b_b,
  // interrupt front end
  input  wire logic [7:0]  i_irq_events,
  input  wire logic [7:0]  i_irq_flag_clr,
  input  wire logic [7:0]  i_eth_irq_enable_reg,
  input  wire logic        i_eth_global_irq_enable,
  output logic      [7:0]  o_eth_irq_flag_reg,
  output logic             o_eth_master_irq_flag
);

  localparam int NLED = 2;

  typedef struct packed {
    logic [2:0]  sync_a;
    logic [2:0]  sync_b;
    logic [15:0] ctrl_one;
    logic [15:0] ctrl_two;
    logic [15:0] led_ctl;
    logic [15:0] irq_en;
    logic        latched_link_up;
    logic        plnk_if;
    logic        pg_if;
    logic        link_prev;
    logic [7:0]  irq_flags;
    logic        master;
    logic [15:0] rdata;
    logic        rvalid;
    logic        full_duplex;
    logic        tx_allowed;
    logic        loop_off;
    logic        rx_normal;
    logic [31:0] fast_cnt;
    logic [31:0] slow_cnt;
    logic        fast_lvl;
    logic        slow_lvl;
    logic [1:0]  leds;
  } state_t;

  state_t      q;
  state_t      d;
  logic        link_up_now;
  logic        tx_active;
  logic        rx_active;
  logic        collision_active;
  logic        link_change;
  logic [15:0] stat_one;
  logic [15:0] stat_two;
  logic [15:0] irq_req;
  logic [31:0] stretch_cyc;
  logic [NLED-1:0] led_raw;

  // ****************************************
  // live status from synchronised pins
  // ****************************************
  assign link_up_now      = q.sync_b[2];
  assign tx_active        = q.sync_b[1];
  assign rx_active        = q.sync_b[0];
  assign collision_active = tx_active & rx_active & ~q.ctrl_one[DUPLEX_BIT];
  assign link_change      = link_up_now ^ q.link_prev;

  always_comb
  begin
    stat_one = STAT_ONE_FIXED;
    stat_one[LATCH_LINK_BIT] = q.latched_link_up;
    stat_two = 16'h0000;
    stat_two[TX_ACT_BIT]   = tx_active;
    stat_two[RX_ACT_BIT]   = rx_active;
    stat_two[COL_BIT]      = collision_active;
    stat_two[LINK_NOW_BIT] = link_up_now;
    irq_req = 16'h0000;
    irq_req[PLNK_IF_BIT] = q.plnk_if;
    irq_req[PG_IF_BIT]   = q.pg_if;
  end

  // ****************************************
  // stretch time select
  // ****************************************
  always_comb
  begin
    case (q.led_ctl[STRETCH_SEL_LSB +: 2])
      2'b01:   stretch_cyc = 32'(STRETCH_M_CYC);
      2'b10:   stretch_cyc = 32'(STRETCH_L_CYC);
      // reserved setting falls back to the normal time
      default: stretch_cyc = 32'(STRETCH_N_CYC);
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    d = q;
    // first stage feeds only the second
    d.sync_a = {i_link_pin, i_tx_pin, i_rx_pin};
    d.sync_b = q.sync_a;
    d.link_prev = link_up_now;
    d.rvalid = 1'b0;

    // whole-word writes, only implemented bits stored except the led word, which is kept whole
    if (i_mii_wr)
    begin
      case (i_mii_addr)
        ADDR_CTRL_ONE: d.ctrl_one = i_mii_wdata & CTRL_ONE_WMASK;
        ADDR_CTRL_TWO: d.ctrl_two = i_mii_wdata & CTRL_TWO_WMASK;
        ADDR_LED_CTL:  d.led_ctl  = i_mii_wdata;
        ADDR_IRQ_EN:   d.irq_en   = i_mii_wdata & IRQ_EN_WMASK;
        default:       d.irq_en   = q.irq_en;
      endcase
    end

    // latch low on loss, reload on read of its register
    if (i_mii_rd && i_mii_addr == ADDR_STAT_ONE)
      d.latched_link_up = link_up_now;
    else
      d.latched_link_up = q.latched_link_up & link_up_now;

    // request flags clear on read, a same-cycle change still sets
    if (i_mii_rd && i_mii_addr == ADDR_IRQ_REQ)
    begin
      d.plnk_if = 1'b0;
      d.pg_if   = 1'b0;
      d.irq_flags[LINK_IRQ_BIT] = 1'b0;
    end
    if (link_change)
    begin
      d.plnk_if = 1'b1;
      if (q.irq_en[PLNK_IE_BIT] && q.irq_en[PGE_IE_BIT])
      begin
        d.pg_if = 1'b1;
        d.irq_flags[LINK_IRQ_BIT] = 1'b1;
      end
    end

    // other sources poll-able whatever the enables say
    d.irq_flags = (d.irq_flags & ~(i_irq_flag_clr & ~8'h10))
                | (i_irq_events & EIR_IMPL_MASK & ~8'h10);
    d.irq_flags = d.irq_flags & EIR_IMPL_MASK;
    d.master = |(d.irq_flags & i_eth_irq_enable_reg) & i_eth_global_irq_enable;

    // read answer one cycle after the strobe
    if (i_mii_rd)
    begin
      d.rvalid = 1'b1;
      case (i_mii_addr)
        ADDR_CTRL_ONE: d.rdata = q.ctrl_one;
        ADDR_STAT_ONE: d.rdata = stat_one;
        ADDR_CTRL_TWO: d.rdata = q.ctrl_two;
        ADDR_STAT_TWO: d.rdata = stat_two;
        ADDR_IRQ_EN:   d.rdata = q.irq_en;
        ADDR_IRQ_REQ:  d.rdata = irq_req;
        ADDR_LED_CTL:  d.rdata = q.led_ctl;
        default:       d.rdata = 16'h0000;
      endcase
    end

    d.full_duplex = q.ctrl_one[DUPLEX_BIT];
    // transmit gated on a partner unless forced up
    d.tx_allowed  = q.ctrl_two[FORCE_LINK_BIT] | link_up_now;
    // mode bits are driven as stored; clearing them is the user's risk
    d.loop_off    = q.ctrl_two[8];
    d.rx_normal   = q.ctrl_two[4];

    // free-running blink bases shared by both leds
    if (q.fast_cnt >= 32'(BLINK_F_CYC - 1))
    begin
      d.fast_cnt = 32'h0000_0000;
      d.fast_lvl = ~q.fast_lvl;
    end
    else
      d.fast_cnt = q.fast_cnt + 32'h0000_0001;
    if (q.slow_cnt >= 32'(BLINK_S_CYC - 1))
    begin
      d.slow_cnt = 32'h0000_0000;
      d.slow_lvl = ~q.slow_lvl;
    end
    else
      d.slow_cnt = q.slow_cnt + 32'h0000_0001;

    d.leds = led_raw;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      q          <= '0;
      q.ctrl_one <= CTRL_ONE_RST;
      q.ctrl_two <= CTRL_TWO_RST;
      q.led_ctl  <= LED_CTL_RST;
      q.irq_en   <= IRQ_EN_RST;
    end
    else if (i_ce)
      q <= d;
  end

  // ****************************************
  // led drivers
  // ****************************************
  generate
    for (genvar g = 0; g < NLED; g++)
    begin : gen_led
      led_drive_if lif ();
      // led a sits above led b in the control word
      assign lif.func        = q.led_ctl[(g == 0 ? LED_A_LSB : LED_B_LSB) +: 4];
      assign lif.stretch_on  = q.led_ctl[STRETCH_ON_BIT];
      assign lif.stretch_cyc = stretch_cyc;
      assign lif.tx          = tx_active;
      assign lif.rx          = rx_active;
      assign lif.col         = collision_active;
      assign lif.link        = link_up_now;
      assign lif.duplex      = q.ctrl_one[DUPLEX_BIT];
      assign lif.blink_fast  = q.fast_lvl;
      assign lif.blink_slow  = q.slow_lvl;
      assign led_raw[g]      = lif.led;
      led_driver u_drv (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .bus     (lif.drv)
      );
    end
  endgenerate

  // ****************************************
  // outputs
  // ****************************************
  assign o_mii_rdata                = q.rdata;
  assign o_mii_rvalid               = q.rvalid;
  assign o_full_duplex              = q.full_duplex;
  assign o_tx_allowed               = q.tx_allowed;
  assign o_half_duplex_loopback_off = q.loop_off;
  assign o_rx_input_normal          = q.rx_normal;
  assign o_led_a_a                  = q.leds[0];
  assign o_led_b_b                  = q.leds[1];
  assign o_eth_irq_flag_reg         = q.irq_flags;
  assign o_eth_master_irq_flag      = q.master;

endmodule

/* sim/phy_regs_asserts.sv */
// checker on the register bank top ports
// assumes binding to the bank; bench holds i_ce high
`timescale 1ns/100ps
module phy_regs_asserts
  import phy_regs_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // management port
  input  wire logic [4:0]  i_mii_addr,
  input  wire logic        i_mii_wr,
  input  wire logic        i_mii_rd,
  input  wire logic [15:0] i_mii_wdata,
  input  wire logic [15:0] o_mii_rdata,
  input  wire logic        o_mii_rvalid,
  // mode and interrupt
  input  wire logic        o_full_duplex,
  input  wire logic [7:0]  i_irq_events,
  input  wire logic [7:0]  i_eth_irq_enable_reg,
  input  wire logic        i_eth_global_irq_enable,
  input  wire logic [7:0]  o_eth_irq_flag_reg,
  input  wire logic        o_eth_master_irq_flag
);
  // ****************************************
  // helpers
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [1:0] wd_q;
  // keeps the duplex bit of the last two cycles, so no bit-select in $past
  always_ff @(posedge i_clk)
  begin
    wd_q <= {wd_q[0], i_mii_wdata[DUPLEX_BIT]};
  end
  sequence rd_of(logic [4:0] a);
    i_ce && i_mii_rd && i_mii_addr == a ##1 o_mii_rvalid;
  endsequence
  sequence wr_one;
    i_ce && i_mii_wr && i_mii_addr == ADDR_CTRL_ONE;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  rd_answer_a: assert property (i_ce && i_mii_rd |=> o_mii_rvalid)
    else $error("read not answered");
  rv_spurious_a: assert property (!(i_ce && i_mii_rd) |=> !o_mii_rvalid)
    else $error("read valid without read");
  ctrl_one_rd_a: assert property (rd_of(ADDR_CTRL_ONE) |->
    (o_mii_rdata & 16'h327F) == 16'h0000)
    else $error("control one unimplemented bit set");
  stat_one_rd_a: assert property (rd_of(ADDR_STAT_ONE) |->
    (o_mii_rdata & 16'hFFFB) == 16'h1800)
    else $error("status one fixed bits wrong");
  stat_two_rd_a: assert property (rd_of(ADDR_STAT_TWO) |->
    (o_mii_rdata & 16'hC1DF) == 16'h0000)
    else $error("status two unimplemented bit set");
  collision_a: assert property (rd_of(ADDR_STAT_TWO) |->
    !o_mii_rdata[11] || (o_mii_rdata[13] && o_mii_rdata[12]))
    else $error("collision without tx and rx");
  duplex_out_a: assert property (wr_one |-> ##2 o_full_duplex == wd_q[1])
    else $error("duplex output does not follow write");
  flag_set_a: assert property (i_ce && i_irq_events[0] |=> o_eth_irq_flag_reg[0])
    else $error("flag not set by event");
  flag_resv_a: assert property (o_eth_irq_flag_reg[7] == 1'b0 && o_eth_irq_flag_reg[2] == 1'b0)
    else $error("unimplemented flag set");
  master_gate_a: assert property (1'b1 |=> o_eth_master_irq_flag ==
    ((|(o_eth_irq_flag_reg & $past(i_eth_irq_enable_reg))) && $past(i_eth_global_irq_enable)))
    else $error("master flag mismatch");
endmodule

/* sim/mac_mgmt_model.sv */
// model of the mac driving the management port
// assumes one-cycle strobes and a registered read answer
`timescale 1ns/100ps
module mac_mgmt_model
  import phy_regs_pkg::*;
(
  // clock
  input  wire logic        i_clk,
  // management port
  output logic      [4:0]  o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [15:0] o_wdata,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid
);
  logic mac_full_duplex;
  initial
  begin
    o_addr = 5'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
    mac_full_duplex = 1'b0;
  end
  // idle lines show the inverse so stale values never pass
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    if (a == ADDR_CTRL_ONE)
    begin
      mac_full_duplex = d[DUPLEX_BIT];
    end
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    int n;
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    o_addr = ~a;
    n = 0;
    while (i_rvalid !== 1'b1 && n < 4)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    d = (i_rvalid === 1'b1) ? i_rdata : 16'hxxxx;
  endtask
  task automatic init();
    wr_reg(ADDR_CTRL_TWO, 16'h0110);
  endtask
endmodule

/* sim/phy_control_status_led_regs_tb.sv */
// self-checking bench for the phy register bank
// assumes the mac model owns the management port
`timescale 1ns/100ps
module phy_control_status_led_regs_tb
  import phy_regs_pkg::*;
;
  localparam int SN = 5;
  localparam int SM = 10;
  localparam int SL = 20;
  typedef struct packed {logic w; logic [4:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  logic clk, rst_n, wr, rd, rvalid, link, tx, rx, full, txok, lpoff, rxn, led_a, led_b;
  logic gen, master;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, v;
  logic [7:0] ev, clr, en, flags;
  int n_errors, checks_done, cyc, cnt, lo, hi, ta, tb;
  row_t rows [13] = '{'{0, ADDR_CTRL_ONE, 0, 0}, '{0, ADDR_STAT_ONE, 0, 16'h1800},
    '{0, ADDR_CTRL_TWO, 0, 0}, '{0, ADDR_STAT_TWO, 0, 0}, '{0, ADDR_IRQ_EN, 0, 0},
    '{0, ADDR_IRQ_REQ, 0, 0}, '{0, ADDR_LED_CTL, 0, 16'h3422}, '{0, 5'h05, 0, 0},
    '{1, ADDR_CTRL_ONE, 16'hFFFF, 16'hCD80}, '{1, ADDR_CTRL_TWO, 16'hFFFF, 16'h7FFF},
    '{1, ADDR_IRQ_EN, 16'hFFFF, 16'h0012}, '{1, ADDR_STAT_ONE, 16'hFFFF, 16'h1800},
    '{1, ADDR_STAT_TWO, 16'hFFFF, 16'h0000}};
  localparam logic [15:0] LED_EXP = 16'h3130;
  mac_mgmt_model mac_u (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
    .i_rdata(rdata), .i_rvalid(rvalid));
  phy_control_status_led_regs #(.STRETCH_N_CYC(SN), .STRETCH_M_CYC(SM), .STRETCH_L_CYC(SL),
    .BLINK_F_CYC(4), .BLINK_S_CYC(8)) dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_mii_addr(addr), .i_mii_wr(wr), .i_mii_rd(rd), .i_mii_wdata(wdata),
    .o_mii_rdata(rdata), .o_mii_rvalid(rvalid), .i_link_pin(link), .i_tx_pin(tx),
    .i_rx_pin(rx), .o_full_duplex(full), .o_tx_allowed(txok),
    .o_half_duplex_loopback_off(lpoff), .o_rx_input_normal(rxn), .o_led_a_a(led_a),
    .o_led_b_b(led_b), .i_irq_events(ev), .i_irq_flag_clr(clr), .i_eth_irq_enable_reg(en),
    .i_eth_global_irq_enable(gen), .o_eth_irq_flag_reg(flags), .o_eth_master_irq_flag(master));
  // ****************************************
  // helpers
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // a hung handshake would otherwise stall the run forever
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    mac_u.rd_reg(a, d);
    chk(d, exp);
  endtask
  task automatic cw(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    {rst_n, link, tx, rx, gen, ev, clr, en} = '0;
    cw(3);
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].w)
        mac_u.wr_reg(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    mac_u.wr_reg(ADDR_CTRL_ONE, 16'h0100);
    mac_u.init();
    mac_u.wr_reg(ADDR_IRQ_EN, 16'h0000);
    cw(3);
    chk(16'({full, lpoff, rxn, txok}), 16'h000E);
    chk(16'(mac_u.mac_full_duplex), 16'h0001);
    link = 1'b1;
    cw(4);
    chk(16'(txok), 16'h0001);
    rdchk(ADDR_STAT_ONE, 16'h1800);
    rdchk(ADDR_STAT_ONE, 16'h1804);
    link = 1'b0;
    cw(4);
    link = 1'b1;
    cw(4);
    rdchk(ADDR_STAT_ONE, 16'h1800);
    rdchk(ADDR_STAT_ONE, 16'h1804);
    {tx, rx} = 2'b11;
    cw(4);
    rdchk(ADDR_STAT_TWO, 16'h3400);
    mac_u.wr_reg(ADDR_CTRL_ONE, 16'h0000);
    cw(3);
    rdchk(ADDR_STAT_TWO, 16'h3C00);
    tx = 1'b0;
    cw(4);
    rdchk(ADDR_STAT_TWO, 16'h1400);
    rx = 1'b0;
    mac_u.wr_reg(ADDR_CTRL_ONE, 16'h0100);
    mac_u.rd_reg(ADDR_IRQ_REQ, v);
    mac_u.wr_reg(ADDR_IRQ_EN, 16'h0012);
    link = 1'b0;
    cw(5);
    chk(16'(flags[4]), 16'h0001);
    rdchk(ADDR_IRQ_REQ, 16'h0014);
    cw(2);
    chk(16'(flags[4]), 16'h0000);
    mac_u.wr_reg(ADDR_IRQ_EN, 16'h0000);
    link = 1'b1;
    cw(5);
    chk(16'(flags[4]), 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      ev[i] = 1'b1;
      cw(1);
      ev = 8'h00;
      cw(1);
      v = (i != 2 && i != 4 && i != 7) ? 16'h0002 : 16'h0000;
      chk(16'({flags[i], master}), v);
    end
    en = 8'h01;
    gen = 1'b1;
    cw(2);
    chk(16'(master), 16'h0001);
    clr = 8'hFF;
    cw(1);
    clr = 8'h00;
    cw(1);
    chk(16'({flags, master}), 16'h0000);
    for (int c = 0; c < 16; c++)
    begin
      if (c != 10 && c != 11)
      begin
        mac_u.wr_reg(ADDR_LED_CTL, 16'h3000 | 16'(c << 8) | 16'((c ^ 1) << 4));
        cw(3);
        chk(16'({led_a, led_b}), 16'({LED_EXP[c], LED_EXP[c ^ 1]}));
      end
    end
    for (int k = 0; k < 4; k++)
    begin
      v = 16'h3290 | 16'((k % 3) << 2) | ((k < 3) ? 16'h0002 : 16'h0000);
      mac_u.wr_reg(ADDR_LED_CTL, v);
      lo = (k == 0) ? SN : (k == 1) ? SM : (k == 2) ? SL : 1;
      hi = (k < 3) ? lo + 2 : 1;
      rx = 1'b1;
      cw(1);
      rx = 1'b0;
      cnt = 0;
      repeat (40)
      begin
        cw(1);
        if (led_a === 1'b1)
          cnt++;
      end
      chk(16'(cnt >= lo && cnt <= hi), 16'h0001);
    end
    mac_u.wr_reg(ADDR_LED_CTL, 16'h3AB0);
    {ta, tb} = '0;
    repeat (64)
    begin
      {lo, hi} = {32'(led_a), 32'(led_b)};
      cw(1);
      ta += (32'(led_a) != lo);
      tb += (32'(led_b) != hi);
    end
    chk(16'({ta >= 15 && ta <= 17, tb >= 7 && tb <= 9}), 16'h0003);
    // mid-run reset: state must return to its reset values
    rst_n = 1'b0;
    cw(2);
    rst_n = 1'b1;
    chk(16'({full, master, flags}), 16'h0000);
    rdchk(ADDR_LED_CTL, 16'h3422);
    rdchk(ADDR_STAT_ONE, 16'h1800);
    cw(3);
    rdchk(ADDR_STAT_ONE, 16'h1804);
    final_report();
  end
endmodule
bind phy_control_status_led_regs phy_regs_asserts chk_u (.i_clk, .i_rst_n, .i_ce, .i_mii_addr,
  .i_mii_wr, .i_mii_rd, .i_mii_wdata, .o_mii_rdata, .o_mii_rvalid, .o_full_duplex,
  .i_irq_events, .i_eth_irq_enable_reg, .i_eth_global_irq_enable, .o_eth_irq_flag_reg,
  .o_eth_master_irq_flag);
